// >>> src/lrcd_pkg.sv
// Package: opcode codes, register fields, cycle counts and decode carrier types
package lrcd_pkg;

	// Register field codes
	localparam logic [2:0] LRCD_REG_B   = 3'h0;
	localparam logic [2:0] LRCD_REG_C   = 3'h1;
	localparam logic [2:0] LRCD_REG_D   = 3'h2;
	localparam logic [2:0] LRCD_REG_E   = 3'h3;
	localparam logic [2:0] LRCD_REG_H   = 3'h4;
	localparam logic [2:0] LRCD_REG_L   = 3'h5;
	localparam logic [2:0] LRCD_REG_MEM = 3'h6;
	localparam logic [2:0] LRCD_REG_ACC = 3'h7;

	// Register-source group prefixes (bits 7..3)
	localparam logic [4:0] LRCD_PFX_AND = 5'h14;
	localparam logic [4:0] LRCD_PFX_XOR = 5'h15;
	localparam logic [4:0] LRCD_PFX_OR  = 5'h16;
	localparam logic [4:0] LRCD_PFX_CMP = 5'h17;

	// Full opcodes
	localparam logic [7:0] LRCD_OP_AND_IMM = 8'hE6;
	localparam logic [7:0] LRCD_OP_XOR_IMM = 8'hEE;
	localparam logic [7:0] LRCD_OP_OR_IMM  = 8'hF6;
	localparam logic [7:0] LRCD_OP_CMP_IMM = 8'hFE;
	localparam logic [7:0] LRCD_OP_RLC     = 8'h07;
	localparam logic [7:0] LRCD_OP_RRC     = 8'h0F;
	localparam logic [7:0] LRCD_OP_RLT     = 8'h17;
	localparam logic [7:0] LRCD_OP_RRT     = 8'h1F;
	localparam logic [7:0] LRCD_OP_INV_A   = 8'h2F;
	localparam logic [7:0] LRCD_OP_SET_CY  = 8'h37;
	localparam logic [7:0] LRCD_OP_INV_CY  = 8'h3F;
	localparam logic [7:0] LRCD_OP_DEC_ADJ = 8'h27;
	localparam logic [7:0] LRCD_OP_INT_ON  = 8'hFB;
	localparam logic [7:0] LRCD_OP_INT_OFF = 8'hF3;
	localparam logic [7:0] LRCD_OP_NOP     = 8'h00;
	localparam logic [7:0] LRCD_OP_HALT    = 8'h76;
	localparam logic [7:0] LRCD_OP_RD_MASK = 8'h20;
	localparam logic [7:0] LRCD_OP_WR_MASK = 8'h30;

	// Cycle counts
	localparam logic [3:0] LRCD_CYC_SHORT = 4'h4;
	localparam logic [3:0] LRCD_CYC_HALT  = 4'h5;
	localparam logic [3:0] LRCD_CYC_LONG  = 4'h7;
	localparam logic [3:0] LRCD_CYC_NONE  = 4'h0;

	// Reset values of outputs
	localparam logic [7:0] LRCD_ACC_RST = 8'h00;

	// Operation classes
	typedef enum logic [4:0] {
		LRCD_OPC_NONE = 5'h00,
		LRCD_OPC_AND  = 5'h01,
		LRCD_OPC_XOR  = 5'h02,
		LRCD_OPC_OR   = 5'h03,
		LRCD_OPC_CMP  = 5'h04,
		LRCD_OPC_RLC  = 5'h05,
		LRCD_OPC_RRC  = 5'h06,
		LRCD_OPC_RLT  = 5'h07,
		LRCD_OPC_RRT  = 5'h08,
		LRCD_OPC_INVA = 5'h09,
		LRCD_OPC_STC  = 5'h0A,
		LRCD_OPC_CMC  = 5'h0B,
		LRCD_OPC_DAA  = 5'h0C,
		LRCD_OPC_EI   = 5'h0D,
		LRCD_OPC_DI   = 5'h0E,
		LRCD_OPC_NOP  = 5'h0F,
		LRCD_OPC_HLT  = 5'h10,
		LRCD_OPC_RIM  = 5'h11,
		LRCD_OPC_SIM  = 5'h12
	} lrcd_op_t;

	// Operand source
	typedef enum logic [1:0] {
		LRCD_SRC_NONE = 2'h0,
		LRCD_SRC_REG  = 2'h1,
		LRCD_SRC_MEM  = 2'h2,
		LRCD_SRC_IMM  = 2'h3
	} lrcd_src_t;

	// Decode result
	typedef struct packed {
		logic      known;
		lrcd_op_t  op;
		lrcd_src_t src;
		logic [2:0] source_reg_field;
		logic [3:0] cycles;
	} lrcd_dec_t;

endpackage

// >>> src/lrcd_decode.sv
// Combinational opcode classifier for the covered groups
`timescale 1ns/100ps
module lrcd_decode
	import lrcd_pkg::*;
(
	input  wire logic [7:0] opcode,
	output lrcd_dec_t       dec
);
	wire logic [4:0] pfx        = opcode[7:3];
	wire logic [2:0] sfield     = opcode[2:0];
	wire logic       is_mem_src = (sfield == LRCD_REG_MEM);
	wire logic       is_reg_grp = (pfx == LRCD_PFX_AND) || (pfx == LRCD_PFX_XOR) ||
	                              (pfx == LRCD_PFX_OR) || (pfx == LRCD_PFX_CMP);

	always_comb begin
		dec                  = '0;
		dec.op               = LRCD_OPC_NONE;
		dec.src              = LRCD_SRC_NONE;
		dec.source_reg_field = sfield;
		dec.cycles           = LRCD_CYC_SHORT;
		dec.known            = 1'b1;
		if (is_reg_grp) begin
			unique case (pfx)
				LRCD_PFX_AND: dec.op = LRCD_OPC_AND;
				LRCD_PFX_XOR: dec.op = LRCD_OPC_XOR;
				LRCD_PFX_OR:  dec.op = LRCD_OPC_OR;
				default:      dec.op = LRCD_OPC_CMP;
			endcase
			dec.src    = is_mem_src ? LRCD_SRC_MEM : LRCD_SRC_REG;
			dec.cycles = is_mem_src ? LRCD_CYC_LONG : LRCD_CYC_SHORT;
		end else begin
			unique case (opcode)
				LRCD_OP_AND_IMM: begin
					dec.op = LRCD_OPC_AND;
					dec.src = LRCD_SRC_IMM;
					dec.cycles = LRCD_CYC_LONG;
				end
				LRCD_OP_XOR_IMM: begin
					dec.op = LRCD_OPC_XOR;
					dec.src = LRCD_SRC_IMM;
					dec.cycles = LRCD_CYC_LONG;
				end
				LRCD_OP_OR_IMM: begin
					dec.op = LRCD_OPC_OR;
					dec.src = LRCD_SRC_IMM;
					dec.cycles = LRCD_CYC_LONG;
				end
				LRCD_OP_CMP_IMM: begin
					dec.op = LRCD_OPC_CMP;
					dec.src = LRCD_SRC_IMM;
					dec.cycles = LRCD_CYC_LONG;
				end
				LRCD_OP_RLC:     dec.op = LRCD_OPC_RLC;
				LRCD_OP_RLT:     dec.op = LRCD_OPC_RLT;
				LRCD_OP_RRC:     dec.op = LRCD_OPC_RRC;
				LRCD_OP_RRT:     dec.op = LRCD_OPC_RRT;
				LRCD_OP_INV_A:   dec.op = LRCD_OPC_INVA;
				LRCD_OP_SET_CY:  dec.op = LRCD_OPC_STC;
				LRCD_OP_INV_CY:  dec.op = LRCD_OPC_CMC;
				LRCD_OP_DEC_ADJ: dec.op = LRCD_OPC_DAA;
				LRCD_OP_INT_ON:  dec.op = LRCD_OPC_EI;
				LRCD_OP_INT_OFF: dec.op = LRCD_OPC_DI;
				LRCD_OP_NOP:     dec.op = LRCD_OPC_NOP;
				LRCD_OP_RD_MASK: dec.op = LRCD_OPC_RIM;
				LRCD_OP_WR_MASK: dec.op = LRCD_OPC_SIM;
				LRCD_OP_HALT: begin
					dec.op = LRCD_OPC_HLT;
					dec.cycles = LRCD_CYC_HALT;
				end
				default: begin
					dec.known = 1'b0;
					dec.cycles = LRCD_CYC_NONE;
				end
			endcase
		end
	end
endmodule

// >>> src/lrcd_top.sv
// Logical, rotate, special and control opcode decoder with cycle timing
//
// Functional notes
// - 1010_0sss AND, 1010_1sss XOR, 1011_0sss OR; register forms take 4 cycles.
// - Source field 110 selects memory operand; memory forms take 7 cycles.
// - E6h AND, EEh XOR, F6h OR immediate; operand is next byte; 7 cycles.
// - Compare: register 1011_1sss in 4, memory BEh in 7, immediate FEh in 7.
// - Three-bit register fields: B,C,D,E,H,L, 110 memory, 111 accumulator.
// - 07h rotates accumulator left circular, 17h left through carry; 4 cycles.
// - 0Fh rotates accumulator right circular, 1Fh right through carry; 4 cycles.
// - Conditional instructions have short and long durations, e.g. 6 or 12.
// - Output levels are undefined until the first reset is applied.
`timescale 1ns/100ps
module lrcd_top
	import lrcd_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	input  wire logic [7:0] fetch_data,
	input  wire logic       fetch_valid,
	input  wire logic       cond_met,
	input  wire logic [3:0] cond_short,
	input  wire logic [3:0] cond_long,
	input  wire logic       cond_valid,
	output lrcd_op_t        op_out,
	output lrcd_src_t       src_out,
	output logic [2:0]      source_reg_field,
	output logic [7:0]      imm_operand,
	output logic            dec_valid,
	output logic            unknown_op,
	output logic            busy,
	output logic            instr_done,
	output logic [3:0]      cycles_total,
	output logic            halted
);
	// Reset synchroniser; rule 10 is served by defined reset values
	logic rst_s1_q;
	logic rst_s2_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire logic rst_n = rst_s2_q;

	typedef enum logic [3:0] {
		LRCD_ST_FETCH = 4'b0001,
		LRCD_ST_IMM   = 4'b0010,
		LRCD_ST_EXEC  = 4'b0100,
		LRCD_ST_HALT  = 4'b1000
	} lrcd_state_t;

	lrcd_state_t state_q;
	lrcd_state_t state_d;
	lrcd_dec_t   dec;
	lrcd_dec_t   dec_q;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [7:0]  imm_q;

	lrcd_decode u_dec (
		.opcode (fetch_data),
		.dec    (dec)
	);

	// Conditional durations chosen by the flag outcome
	wire logic [3:0] cond_cycles = cond_met ? cond_long : cond_short;
	wire logic       take_op     = (state_q == LRCD_ST_FETCH) && fetch_valid;
	wire logic       take_cond   = (state_q == LRCD_ST_FETCH) && !fetch_valid && cond_valid;
	wire logic [3:0] new_cycles  = take_cond ? cond_cycles : dec.cycles;
	wire logic       need_imm    = dec.known && (dec.src == LRCD_SRC_IMM);
	wire logic       last_cyc    = (cnt_q <= 4'h1);

	always_comb begin
		state_d = state_q;
		cnt_d   = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
		unique case (state_q)
			LRCD_ST_FETCH: begin
				if (take_op && dec.known) begin
					cnt_d   = dec.cycles - 4'h1;
					state_d = need_imm ? LRCD_ST_IMM : LRCD_ST_EXEC;
				end else if (take_cond && cond_cycles != 4'h0) begin
					cnt_d   = cond_cycles - 4'h1;
					state_d = LRCD_ST_EXEC;
				end
			end
			LRCD_ST_IMM: begin
				// Count holds while the operand byte is late
				cnt_d = cnt_q;
				if (fetch_valid) begin
					cnt_d   = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
					state_d = LRCD_ST_EXEC;
				end
			end
			LRCD_ST_EXEC: begin
				if (last_cyc) begin
					state_d = (dec_q.op == LRCD_OPC_HLT) ? LRCD_ST_HALT : LRCD_ST_FETCH;
				end
			end
			LRCD_ST_HALT: state_d = LRCD_ST_HALT;
			default: begin
				state_d = LRCD_ST_FETCH;
				cnt_d   = 4'h0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= LRCD_ST_FETCH;
			cnt_q   <= 4'h0;
			dec_q   <= '0;
			imm_q   <= LRCD_ACC_RST;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			if (take_op) begin
				dec_q <= dec;
			end else if (take_cond) begin
				dec_q <= '{known: 1'b1, op: LRCD_OPC_NONE, src: LRCD_SRC_NONE,
				           source_reg_field: 3'h0, cycles: cond_cycles};
			end
			if (state_q == LRCD_ST_IMM && fetch_valid) begin
				imm_q <= fetch_data;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			op_out           <= LRCD_OPC_NONE;
			src_out          <= LRCD_SRC_NONE;
			source_reg_field <= 3'h0;
			imm_operand      <= LRCD_ACC_RST;
			dec_valid        <= 1'b0;
			unknown_op       <= 1'b0;
			busy             <= 1'b0;
			instr_done       <= 1'b0;
			cycles_total     <= LRCD_CYC_NONE;
			halted           <= 1'b0;
		end else if (clk_en) begin
			dec_valid  <= (take_op && dec.known) || take_cond;
			unknown_op <= take_op && !dec.known;
			if (take_op && dec.known) begin
				op_out           <= dec.op;
				src_out          <= dec.src;
				source_reg_field <= dec.source_reg_field;
				cycles_total     <= new_cycles;
			end else if (take_cond) begin
				op_out       <= LRCD_OPC_NONE;
				src_out      <= LRCD_SRC_NONE;
				cycles_total <= cond_cycles;
			end
			if (state_q == LRCD_ST_IMM && fetch_valid) begin
				imm_operand <= fetch_data;
			end
			busy       <= (state_d != LRCD_ST_FETCH) && (state_d != LRCD_ST_HALT);
			instr_done <= (state_q == LRCD_ST_EXEC) && last_cyc;
			halted     <= (state_d == LRCD_ST_HALT);
		end
	end
endmodule

// >>> tb/lrcd_chk.sv
// Checker: decode and timing relations at the decoder ports
`timescale 1ns/100ps
module lrcd_chk
	import lrcd_pkg::*;
(
	input wire logic       mclk,
	input wire logic       nrst,
	input wire lrcd_op_t   op_out,
	input wire lrcd_src_t  src_out,
	input wire logic [2:0] source_reg_field,
	input wire logic       dec_valid,
	input wire logic       instr_done,
	input wire logic [3:0] cycles_total,
	input wire logic       halted
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	reg_form_a: assert property (dec_valid && src_out == LRCD_SRC_REG |->
		cycles_total == 4'h4 ##3 instr_done) else $error("register form timing");
	mem_form_a: assert property (dec_valid && src_out == LRCD_SRC_MEM |->
		source_reg_field == 3'h6 && cycles_total == 4'h7 ##6 instr_done) else $error("memory form");
	imm_form_a: assert property (dec_valid && src_out == LRCD_SRC_IMM |->
		cycles_total == 4'h7) else $error("immediate form count");
	rot_left_a: assert property (dec_valid && op_out inside {LRCD_OPC_RLC, LRCD_OPC_RLT} |->
		cycles_total == 4'h4 ##3 instr_done) else $error("left rotate timing");
	rot_right_a: assert property (dec_valid && op_out inside {LRCD_OPC_RRC, LRCD_OPC_RRT} |->
		cycles_total == 4'h4 ##3 instr_done) else $error("right rotate timing");
	acc_special_a: assert property (dec_valid && op_out inside {[LRCD_OPC_INVA:LRCD_OPC_DAA]} |->
		cycles_total == 4'h4 ##3 instr_done) else $error("special timing");
	halt_timing_a: assert property (dec_valid && op_out == LRCD_OPC_HLT |->
		cycles_total == 4'h5 ##4 instr_done ##1 halted) else $error("halt timing");
	halt_hold_a: assert property (halted |=> halted && !dec_valid)
		else $error("halt left without reset");
endmodule
bind lrcd_top lrcd_chk u_chk (
	.mclk(mclk), .nrst(nrst), .op_out(op_out), .src_out(src_out),
	.source_reg_field(source_reg_field), .dec_valid(dec_valid), .instr_done(instr_done),
	.cycles_total(cycles_total), .halted(halted)
);

// >>> tb/lrcd_pmem.sv
// Program memory model: presents opcode and operand bytes
`timescale 1ns/100ps
module lrcd_pmem
	import lrcd_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic [7:0] op_b,
	input  wire logic [3:0] gap,
	output logic [7:0]      fetch_data,
	output logic            fetch_valid
);
	int        wait_q = 0;
	wire logic imm_w = op_b inside {LRCD_OP_AND_IMM, LRCD_OP_XOR_IMM, LRCD_OP_OR_IMM, LRCD_OP_CMP_IMM};
	initial begin
		fetch_data = 8'h00;
		fetch_valid = 1'b0;
	end
	always @(negedge mclk) begin
		fetch_valid <= 1'b0;
		fetch_data <= ~fetch_data;
		if (go) begin
			fetch_valid <= 1'b1;
			fetch_data <= op_b;
			wait_q <= imm_w ? gap + 1 : 0;
		end else if (wait_q == 1) begin
			fetch_valid <= 1'b1;
			fetch_data <= 8'h5A; // Operand after opcode
			wait_q <= 0;
		end else if (wait_q > 1)
			wait_q <= wait_q - 1;
	end
endmodule

// >>> tb/testbench.sv
// Testbench: decode and timing of the covered opcode groups
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	import lrcd_pkg::*;
	typedef struct packed {
		logic [7:0] code;
		lrcd_op_t   op;
		lrcd_src_t  src;
		logic [3:0] cyc;
	} lrcd_row_t;
	logic       mclk = 0, nrst = 0, go = 0, cond_valid = 0, cond_met = 0, dv, unk;
	logic [7:0] op_b = 8'h00, fetch_data, imm_operand;
	logic [3:0] gap = 4'h0, cond_short = 4'h6, cond_long = 4'hC, cycles_total;
	logic       fetch_valid, dec_valid, unknown_op, busy, instr_done, halted;
	lrcd_op_t   op_out;
	lrcd_src_t  src_out;
	logic [2:0] source_reg_field;
	int         err_count = 0, n_compared = 0, n, i, g;
	lrcd_row_t  rows[$];
	logic [7:0] spec[13] = '{8'h07, 8'h0F, 8'h17, 8'h1F, 8'h2F, 8'h37, 8'h3F,
		8'h27, 8'hFB, 8'hF3, 8'h00, 8'h20, 8'h30};
	lrcd_top uut (.mclk(mclk), .nrst(nrst), .clk_en(1'b1), .fetch_data(fetch_data),
		.fetch_valid(fetch_valid), .cond_met(cond_met), .cond_short(cond_short),
		.cond_long(cond_long), .cond_valid(cond_valid), .op_out(op_out), .src_out(src_out),
		.source_reg_field(source_reg_field), .imm_operand(imm_operand), .dec_valid(dec_valid),
		.unknown_op(unknown_op), .busy(busy), .instr_done(instr_done),
		.cycles_total(cycles_total), .halted(halted));
	lrcd_pmem pm (.mclk(mclk), .go(go), .op_b(op_b), .gap(gap), .fetch_data(fetch_data),
		.fetch_valid(fetch_valid));
	initial forever #4 mclk = ~mclk;
	task complete_run;
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic run(input logic [7:0] code, input logic [3:0] gp, input logic cnd);
		if (!cnd) begin
			@(negedge mclk);
			op_b = code;
			gap = gp;
			go <= 1'b1;
		end
		@(negedge mclk);
		go <= 1'b0;
		cond_valid = cnd;
		n = 0;
		dv = 0;
		unk = 0;
		repeat (40) begin
			@(negedge mclk);
			cond_valid = 1'b0;
			#1;
			n++;
			if (dec_valid === 1'b1) dv = 1'b1;
			if (unknown_op === 1'b1) unk = 1'b1;
			if (instr_done === 1'b1 || unk) break;
		end
		if (instr_done !== 1'b1 && !unk) begin
			err_count++;
			complete_run();
		end
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		`CHK({dec_valid, busy, instr_done, halted}, 4'h0)
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		for (g = 0; g < 4; g++) begin
			for (i = 0; i < 8; i++)
				rows.push_back('{{LRCD_PFX_AND + 5'(g), 3'(i)}, lrcd_op_t'(g + 1),
					i == 6 ? LRCD_SRC_MEM : LRCD_SRC_REG, i == 6 ? 4'h7 : 4'h4});
			rows.push_back('{8'hE6 + 8'(8 * g), lrcd_op_t'(g + 1), LRCD_SRC_IMM, 4'h7});
		end
		for (i = 0; i < 13; i++)
			rows.push_back('{spec[i], lrcd_op_t'(i < 11 ? i + 5 : i + 6), LRCD_SRC_NONE, 4'h4});
		foreach (rows[k]) begin
			run(rows[k].code, 4'h0, 1'b0);
			`CHK({dv, op_out, src_out, cycles_total, 4'(n)}, {1'b1, rows[k].op, rows[k].src, rows[k].cyc, rows[k].cyc})
			if (rows[k].src inside {LRCD_SRC_REG, LRCD_SRC_MEM})
				`CHK(source_reg_field, rows[k].code[2:0])
			if (rows[k].src == LRCD_SRC_IMM)
				`CHK(imm_operand, 8'h5A)
		end
		run(8'hEE, 4'h2, 1'b0);
		`CHK({4'(n), imm_operand}, {4'h9, 8'h5A})
		run(8'h80, 4'h0, 1'b0);
		`CHK({unk, dv, busy}, 3'b100)
		cond_met = 1'b1;
		run(8'h00, 4'h0, 1'b1);
		`CHK(4'(n), 4'hC)
		cond_met = 1'b0;
		run(8'h00, 4'h0, 1'b1);
		`CHK(4'(n), 4'h6)
		run(LRCD_OP_HALT, 4'h0, 1'b0);
		`CHK({op_out, 4'(n)}, {LRCD_OPC_HLT, 4'h5})
		@(negedge mclk);
		op_b = 8'hA0;
		go <= 1'b1;
		repeat (8) @(negedge mclk);
		go <= 1'b0;
		`CHK({busy, halted, op_out}, {2'b01, LRCD_OPC_HLT})
		nrst = 1'b0;
		#1;
		`CHK({halted, op_out}, {1'b0, LRCD_OPC_NONE})
		repeat (10) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		run(8'hA0, 4'h0, 1'b0);
		`CHK({op_out, 4'(n)}, {LRCD_OPC_AND, 4'h4})
		complete_run();
	end
endmodule
